// ---- hw/sfdp_basic_param_rom.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Functional notes
// - Byte 30h returns E5h, 4-KB erase uniform
// - Byte 30h bits 7:5 read all ones
// - Byte 30h bits 4:3 read 00b
// - Byte 30h bit 2 reads one
// - Byte 31h returns erase opcode 20h
// - Byte 32h returns F1h, read modes supported
// - Double-transfer-rate support bit reads zero
// - Address-byte field reads 00b, three-byte only
// - Byte 33h reads FFh, reserved
// - Bytes 34h-37h hold density 01FFFFFFh
// - Byte 38h returns 44h quad addr-data timing
// - Byte 39h returns EBh quad addr-data opcode
// - Byte 3Ah returns 08h quad output timing
// - Byte 3Bh returns 6Bh quad output opcode
// - Byte 3Ch returns 08h dual output timing
// - Byte 3Dh returns 3Bh dual output opcode
// - Byte 3Eh returns 80h dual addr-data timing
// - Byte 3Fh returns BBh dual addr-data opcode
// - Table starts at parameter byte 30h
// - Table length is 10h double words
// ==========================================================================
module sfdp_basic_param_rom
  import sfdp_pkg::*;
(
  input  wire logic        core_clk,      // 25 MHz clock
  input  wire logic        reset_n,       // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [7:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready   // Read data ready
);

  // ========================================================================
  // State
  logic [7:0]     ptr_q;      // Byte pointer into parameter space
  logic [7:0]     ptr_d;
  logic           awHeld_q;   // Write address taken, awaiting data
  logic           wHeld_q;    // Write data taken, awaiting address
  logic [7:0]     awAddr_q;
  logic [31:0]    wData_q;
  logic [3:0]     wStrb_q;
  logic           bValid_q;
  logic [1:0]     bResp_q;
  sfdp_rd_state_t rdState_q;
  logic [7:0]     rdAddr_q;
  logic [31:0]    rData_q;
  logic [1:0]     rResp_q;
  logic [2:0]     rdCnt_q;    // Read sequencing step
  logic [31:0]    dwAcc_q;    // Double word being assembled
  logic [7:0]     romData;
  logic           romHit;
  logic [7:0]     romAddr;

  // ========================================================================
  // Address decode helpers
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == SFDP_REG_ADDR) || (a == SFDP_REG_DATA) ||
             (a == SFDP_REG_STATUS) || (a == SFDP_REG_DWORD);
  endfunction

  // ========================================================================
  // Lookup instance
  sfdp_param_rom u_rom (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .byteAddr   (romAddr),
    .byteData_q (romData),
    .inRange_q  (romHit)
  );

  // ========================================================================
  // Write channel handshakes
  wire awTake  = s_axi_awvalid && s_axi_awready;
  wire wTake   = s_axi_wvalid && s_axi_wready;
  wire haveAw  = awHeld_q || awTake;
  wire haveW   = wHeld_q || wTake;
  wire wrFire  = haveAw && haveW && !bValid_q;
  wire [7:0]  wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
  wire [31:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
  wire [3:0]  wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
  wire wrPtr   = wrFire && (wrAddr == SFDP_REG_ADDR) && wrStrb[0];
  wire wrOk    = (wrAddr == SFDP_REG_ADDR);

  assign s_axi_awready = !awHeld_q && !bValid_q;
  assign s_axi_wready  = !wHeld_q && !bValid_q;
  assign s_axi_bvalid  = bValid_q;
  assign s_axi_bresp   = bResp_q;

  // Pointer is the only writable state; table content has no write path
  assign ptr_d = wrPtr ? wrData[7:0] : ptr_q;

  // Write channel registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q  <= SFDP_RESP_OKAY;
    end else begin
      if (awTake && !wrFire) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake && !wrFire) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q  <= wrOk ? SFDP_RESP_OKAY : SFDP_RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Read channel: DATA returns one byte and advances the pointer,
  // DWORD returns four ascending bytes packed little-endian.
  wire arTake   = s_axi_arvalid && s_axi_arready;
  wire isData   = (rdAddr_q == SFDP_REG_DATA);
  wire isDword  = (rdAddr_q == SFDP_REG_DWORD);
  wire rdMapped = mapped(rdAddr_q);
  wire [7:0] dwBase = {ptr_q[7:2], 2'b00};

  assign s_axi_arready = (rdState_q == SFDP_RD_IDLE);
  assign s_axi_rvalid  = (rdState_q == SFDP_RD_RESP) && (rdCnt_q == 3'd0);
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
  // Step 5..2 presents bytes 0..3; registered lookup returns each one step later
  assign romAddr       = isDword ? (dwBase + {5'd0, 3'd5 - rdCnt_q}) : ptr_q;

  // Status word: table base, table length in double words, pointer
  wire [31:0] statusWord = {8'h00, SFDP_TABLE_DWORDS, SFDP_TABLE_BASE, ptr_q};

  // Read channel sequencing
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rdState_q <= SFDP_RD_IDLE;
      rdAddr_q  <= 8'h00;
      rData_q   <= 32'h0000_0000;
      rResp_q   <= SFDP_RESP_OKAY;
      rdCnt_q   <= 3'd0;
      dwAcc_q   <= 32'h0000_0000;
      ptr_q     <= SFDP_ADDR_RESET;
    end else begin
      ptr_q <= ptr_d;
      case (rdState_q)
        SFDP_RD_IDLE: begin
          if (arTake) begin
            rdAddr_q  <= s_axi_araddr;
            rdState_q <= SFDP_RD_RESP;
            rdCnt_q   <= (s_axi_araddr == SFDP_REG_DWORD) ? 3'd5 :
                         (s_axi_araddr == SFDP_REG_DATA) ? 3'd2 : 3'd1;
          end
        end
        SFDP_RD_RESP: begin
          if (rdCnt_q == 3'd1) begin
            rResp_q <= rdMapped ? SFDP_RESP_OKAY : SFDP_RESP_SLVERR;
            if (isData) begin
              rData_q <= {24'h00_0000, romData};
              if (!wrPtr) begin
                ptr_q <= ptr_q + 8'd1;
              end
            end else if (isDword) begin
              rData_q <= {romData, dwAcc_q[31:8]};
            end else if (rdAddr_q == SFDP_REG_ADDR) begin
              rData_q <= {24'h00_0000, ptr_q};
            end else if (rdAddr_q == SFDP_REG_STATUS) begin
              rData_q <= statusWord;
            end else begin
              rData_q <= 32'h0000_0000;
            end
          end else if (isDword && rdCnt_q < 3'd5 && rdCnt_q > 3'd1) begin
            dwAcc_q <= {romData, dwAcc_q[31:8]};
          end
          if (rdCnt_q != 3'd0) begin
            rdCnt_q <= rdCnt_q - 3'd1;
          end else if (s_axi_rready) begin
            rdState_q <= SFDP_RD_IDLE;
          end
        end
        default: rdState_q <= SFDP_RD_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Checks
  rdata_stable_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data changed while stalled");

  first_dword_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (arTake && s_axi_araddr == SFDP_REG_DWORD && ptr_q[7:2] == 6'h0C && !wrFire)
      |-> ##6 (s_axi_rvalid && s_axi_rdata == 32'hFF_F1_20_E5))
    else $error("first table double word wrong");

  density_dword_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (arTake && s_axi_araddr == SFDP_REG_DWORD && ptr_q[7:2] == 6'h0D && !wrFire)
      |-> ##6 (s_axi_rdata == 32'h01FF_FFFF))
    else $error("density double word wrong");

  quad_dword_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (arTake && s_axi_araddr == SFDP_REG_DWORD && ptr_q[7:2] == 6'h0E && !wrFire)
      |-> ##6 (s_axi_rdata == 32'h6B_08_EB_44))
    else $error("quad timing double word wrong");

  dual_dword_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (arTake && s_axi_araddr == SFDP_REG_DWORD && ptr_q[7:2] == 6'h0F && !wrFire)
      |-> ##6 (s_axi_rdata == 32'hBB_80_3B_08))
    else $error("dual timing double word wrong");

  data_advance_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (arTake && s_axi_araddr == SFDP_REG_DATA) ##1 (!wrPtr) ##1 (!wrPtr)
      |=> (ptr_q == $past(ptr_q, 2) + 8'd1))
    else $error("byte read did not advance pointer");

  status_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (arTake && s_axi_araddr == SFDP_REG_STATUS) |-> ##2 (s_axi_rdata[23:8] == 16'h10_30))
    else $error("status table base or length wrong");

  write_resp_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wrFire |=> (s_axi_bvalid && (s_axi_bresp == SFDP_RESP_OKAY) == $past(wrOk)))
    else $error("write response wrong");

endmodule

// ---- hw/sfdp_pkg.sv ----
// ==========================================================================
// Shared constants for the basic parameter table lookup
package sfdp_pkg;

  // Table placement in the discoverable-parameter space
  localparam logic [7:0]  SFDP_TABLE_BASE   = 8'h30;
  localparam logic [7:0]  SFDP_TABLE_DWORDS = 8'h10;
  localparam logic [7:0]  SFDP_COVERED_LAST = 8'h3F;

  // Byte 30h and 31h fields
  localparam logic [2:0]  SFDP_B30_UNUSED   = 3'h7;
  localparam logic [1:0]  SFDP_B30_SRWRITE  = 2'h0;
  localparam logic        SFDP_B30_BUFBIG   = 1'b1;
  localparam logic [1:0]  SFDP_B30_ERASE4K  = 2'h1;
  localparam logic [7:0]  SFDP_ERASE4K_OP   = 8'h20;

  // Byte 32h and 33h fields
  localparam logic        SFDP_B32_UNUSED    = 1'b1;
  localparam logic        SFDP_QUAD_OUT_SUP  = 1'b1;
  localparam logic        SFDP_QUAD_AD_SUP   = 1'b1;
  localparam logic        SFDP_DUAL_AD_SUP   = 1'b1;
  localparam logic        SFDP_DTR_SUP       = 1'b0;
  localparam logic [1:0]  SFDP_ADDR_BYTES    = 2'h0;
  localparam logic        SFDP_SINGLE_FR_SUP = 1'b1;
  localparam logic [7:0]  SFDP_B33_RSVD      = 8'hFF;

  // Density, zero based, in bits
  localparam logic [31:0] SFDP_DENSITY      = 32'h01FF_FFFF;

  // Fast read timing and opcodes: mode clocks, dummy clocks, opcode
  localparam logic [2:0]  SFDP_QAD_MODE     = 3'h2;
  localparam logic [4:0]  SFDP_QAD_DUMMY    = 5'h04;
  localparam logic [7:0]  SFDP_QAD_OP       = 8'hEB;
  localparam logic [2:0]  SFDP_QO_MODE      = 3'h0;
  localparam logic [4:0]  SFDP_QO_DUMMY     = 5'h08;
  localparam logic [7:0]  SFDP_QO_OP        = 8'h6B;
  localparam logic [2:0]  SFDP_DO_MODE      = 3'h0;
  localparam logic [4:0]  SFDP_DO_DUMMY     = 5'h08;
  localparam logic [7:0]  SFDP_DO_OP        = 8'h3B;
  localparam logic [2:0]  SFDP_DAD_MODE     = 3'h4;
  localparam logic [4:0]  SFDP_DAD_DUMMY    = 5'h00;
  localparam logic [7:0]  SFDP_DAD_OP       = 8'hBB;

  // Register map (byte addresses, AXI4-Lite)
  localparam logic [7:0]  SFDP_REG_ADDR     = 8'h00;
  localparam logic [7:0]  SFDP_REG_DATA     = 8'h04;
  localparam logic [7:0]  SFDP_REG_STATUS   = 8'h08;
  localparam logic [7:0]  SFDP_REG_DWORD    = 8'h0C;
  localparam logic [7:0]  SFDP_ADDR_RESET   = 8'h30;
  localparam logic [1:0]  SFDP_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  SFDP_RESP_SLVERR  = 2'h2;

  // Read channel states
  typedef enum logic [0:0] {
    SFDP_RD_IDLE = 1'b0,
    SFDP_RD_RESP = 1'b1
  } sfdp_rd_state_t;

endpackage

// ---- hw/sfdp_param_rom.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Constant byte lookup of table bytes 30h..3Fh, registered output
module sfdp_param_rom
  import sfdp_pkg::*;
(
  input  wire logic       core_clk,   // Clock
  input  wire logic       reset_n,    // Synchronous reset, active low
  input  wire logic [7:0] byteAddr,   // Absolute parameter byte address
  output logic      [7:0] byteData_q, // Byte at byteAddr, one cycle later
  output logic            inRange_q   // Address fell in 30h..3Fh
);

  logic [7:0] romByte;
  wire        hit = (byteAddr >= SFDP_TABLE_BASE) && (byteAddr <= SFDP_COVERED_LAST);

  // Table content, no write path exists
  always_comb begin
    case (byteAddr[3:0])
      4'h0:    romByte = {SFDP_B30_UNUSED, SFDP_B30_SRWRITE, SFDP_B30_BUFBIG,
                          SFDP_B30_ERASE4K};
      4'h1:    romByte = SFDP_ERASE4K_OP;
      4'h2:    romByte = {SFDP_B32_UNUSED, SFDP_QUAD_OUT_SUP, SFDP_QUAD_AD_SUP,
                          SFDP_DUAL_AD_SUP, SFDP_DTR_SUP, SFDP_ADDR_BYTES,
                          SFDP_SINGLE_FR_SUP};
      4'h3:    romByte = SFDP_B33_RSVD;
      4'h4:    romByte = SFDP_DENSITY[7:0];
      4'h5:    romByte = SFDP_DENSITY[15:8];
      4'h6:    romByte = SFDP_DENSITY[23:16];
      4'h7:    romByte = SFDP_DENSITY[31:24];
      4'h8:    romByte = {SFDP_QAD_MODE, SFDP_QAD_DUMMY};
      4'h9:    romByte = SFDP_QAD_OP;
      4'hA:    romByte = {SFDP_QO_MODE, SFDP_QO_DUMMY};
      4'hB:    romByte = SFDP_QO_OP;
      4'hC:    romByte = {SFDP_DO_MODE, SFDP_DO_DUMMY};
      4'hD:    romByte = SFDP_DO_OP;
      4'hE:    romByte = {SFDP_DAD_MODE, SFDP_DAD_DUMMY};
      4'hF:    romByte = SFDP_DAD_OP;
      default: romByte = 8'h00;
    endcase
  end

  // Output register; outside the covered range reads FFh
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      byteData_q <= 8'h00;
      inRange_q  <= 1'b0;
    end else begin
      byteData_q <= hit ? romByte : 8'hFF;
      inRange_q  <= hit;
    end
  end

  // Quad address-data opcode byte 39h holds its fixed value
  qad_opcode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (byteAddr == 8'h39) |=> (byteData_q == 8'hEB && inRange_q))
    else $error("quad address-data opcode byte wrong");

endmodule

// ---- tb/sfdp_axi_host.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Register-bus host that walks the parameter table over AXI4-Lite
module sfdp_axi_host
  import sfdp_pkg::*;
(
  input  wire logic        core_clk,      // Clock
  output logic      [7:0]  s_axi_awaddr,  // Write address
  output logic             s_axi_awvalid, // Write address valid
  input  wire logic        s_axi_awready, // Write address ready
  output logic      [31:0] s_axi_wdata,   // Write data
  output logic      [3:0]  s_axi_wstrb,   // Write byte strobes
  output logic             s_axi_wvalid,  // Write data valid
  input  wire logic        s_axi_wready,  // Write data ready
  input  wire logic [1:0]  s_axi_bresp,   // Write response
  input  wire logic        s_axi_bvalid,  // Write response valid
  output logic             s_axi_bready,  // Write response ready
  output logic      [7:0]  s_axi_araddr,  // Read address
  output logic             s_axi_arvalid, // Read address valid
  input  wire logic        s_axi_arready, // Read address ready
  input  wire logic [31:0] s_axi_rdata,   // Read data
  input  wire logic [1:0]  s_axi_rresp,   // Read response
  input  wire logic        s_axi_rvalid,  // Read data valid
  output logic             s_axi_rready   // Read data ready
);
  // Idle bus at time zero
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h00;
    s_axi_wdata  = 32'h0000_0000;
    s_axi_wstrb  = 4'h0;
    s_axi_araddr = 8'h00;
  end

  // Write: both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone  = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a; // Released lines do not keep the value
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read: address held until taken, rready held until data arrives
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr  <= ~a;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Four ascending byte reads packed lowest byte first
  task automatic rd_dword_bytes(output logic [31:0] w);
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 4; k++) begin
      rd(SFDP_REG_DATA, d, r);
      w[8*k +: 8] = d[7:0];
    end
  endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the parameter table lookup
module tb_top;
  import sfdp_pkg::*;
  logic        core_clk;
  logic        reset_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, w;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] expDw [4];
  int          error_cnt;
  int          tests_run;

  // ==========================================================================
  // Clock and instances
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  sfdp_basic_param_rom DUT (.core_clk(core_clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  sfdp_axi_host host (.core_clk(core_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    error_cnt = 0;
    tests_run = 0;
    expDw[0] = 32'hFFF1_20E5;
    expDw[1] = 32'h01FF_FFFF;
    expDw[2] = 32'h6B08_EB44;
    expDw[3] = 32'hBB80_3B08;
    reset_n = 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    // Table placement after reset
    host.rd(SFDP_REG_ADDR, w, r);
    chk(w, 32'h0000_0030, "pointer after reset");
    host.rd(SFDP_REG_STATUS, w, r);
    chk(w, 32'h0010_3030, "status word");
    // Ascending byte walk through all four double words
    for (int i = 0; i < 4; i++) begin
      host.rd_dword_bytes(w);
      chk(w, expDw[i], "byte walk");
    end
    host.rd(SFDP_REG_ADDR, w, r);
    chk(w, 32'h0000_0040, "pointer after walk");
    // Whole-word reads at each aligned pointer
    for (int i = 0; i < 4; i++) begin
      host.wr(SFDP_REG_ADDR, 32'h0000_0030 + 32'(4 * i), 4'h1, r);
      chk(32'(r), 32'(SFDP_RESP_OKAY), "pointer write response");
      host.rd(SFDP_REG_DWORD, w, r);
      chk(w, expDw[i], "dword read");
    end
    // Field views of the first double word
    host.wr(SFDP_REG_ADDR, 32'h0000_0030, 4'h1, r);
    host.rd(SFDP_REG_DWORD, w, r);
    chk(32'(w[7:5]), 32'h0000_0007, "unused bits");
    chk(32'(w[4:3]), 32'h0000_0000, "status write field");
    chk(32'(w[2]), 32'h0000_0001, "buffer size bit");
    chk(32'(w[1:0]), 32'h0000_0001, "erase field");
    chk(32'(w[19]), 32'h0000_0000, "dtr bit");
    chk(32'(w[18:17]), 32'h0000_0000, "address bytes");
    chk(32'(w[23:20]), 32'h0000_000F, "read mode bits");
    // Writes aimed at read-only registers are refused, a pointer write with no strobe is ignored; nothing changes
    host.wr(SFDP_REG_DATA, 32'h0000_0000, 4'hF, r);
    chk(32'(r), 32'(SFDP_RESP_SLVERR), "data write refused");
    host.wr(SFDP_REG_DWORD, 32'h0000_0000, 4'hF, r);
    chk(32'(r), 32'(SFDP_RESP_SLVERR), "dword write refused");
    host.wr(SFDP_REG_STATUS, 32'h0000_0000, 4'hF, r);
    chk(32'(r), 32'(SFDP_RESP_SLVERR), "status write refused");
    host.wr(SFDP_REG_ADDR, 32'h0000_0034, 4'h0, r);
    host.rd(SFDP_REG_ADDR, w, r);
    chk(w, 32'h0000_0030, "pointer without strobe");
    host.rd(SFDP_REG_DWORD, w, r);
    chk(w, expDw[0], "table unchanged");
    // Tail bytes of the table then first byte past it
    host.wr(SFDP_REG_ADDR, 32'h0000_003E, 4'h1, r);
    host.rd(SFDP_REG_DATA, w, r);
    chk(32'(w[7:0]), 32'h0000_0080, "byte 3Eh");
    host.rd(SFDP_REG_DATA, w, r);
    chk(32'(w[7:0]), 32'h0000_00BB, "byte 3Fh");
    host.rd(SFDP_REG_DATA, w, r);
    chk(32'(w[7:0]), 32'h0000_00FF, "byte past table");
    // Unmapped read
    host.rd(8'h10, w, r);
    chk(32'(r), 32'(SFDP_RESP_SLVERR), "unmapped response");
    chk(w, 32'h0000_0000, "unmapped data");
    stop_test();
  end
endmodule
